// *** src/bsfw_defs.svh ***
// Constants for the boot strap and fast wake block.
`ifndef BSFW_DEFS_SVH
`define BSFW_DEFS_SVH
`define BSFW_CLK_MHZ        32'd50
`define BSFW_FAULT_WAIT_US  32'd1500
`define BSFW_FAULT_WAIT_CYC (`BSFW_FAULT_WAIT_US * `BSFW_CLK_MHZ)
`define BSFW_CNT_W          17
`define BSFW_ADDR_W         4
`define BSFW_ADDR_CTRL      4'h0
`define BSFW_ADDR_STAT      4'h4
`define BSFW_ADDR_CFG       4'h8
`define BSFW_CTRL_GO        0
`define BSFW_CTRL_SLEEP     1
`define BSFW_CTRL_WAKEREQ   2
`define BSFW_LEGACY_SOCKET  2'h0
`define BSFW_HA_TRACKERS    8'h80
`define BSFW_SIDEBAND_MGMT_BUS_BASE      8'h30
`define BSFW_NODE_BASE      3'h0
`endif

// *** src/bsfw_pkg.sv ***
// Types used by the socket end of the boot strap and fast wake link.
package bsfw_pkg;
  typedef enum logic [2:0] {
    BSFW_OFF     = 3'b000,
    BSFW_ALIGN   = 3'b001,
    BSFW_MINCFG  = 3'b010,
    BSFW_WAIT_GO = 3'b011,
    BSFW_BOOT    = 3'b100,
    BSFW_RUN     = 3'b101
  } bsfw_state_e;
  typedef enum logic [1:0] {
    BSFW_PM_ACTIVE = 2'b00,
    BSFW_PM_SLEEP  = 2'b01
  } bsfw_pm_e;
endpackage : bsfw_pkg

// *** src/bsfw_link_if.sv ***
// Board-level link between the socket and the platform logic.
`timescale 1ns/1ps
`default_nettype none
interface bsfw_link_if;
  logic       power_stable_in;
  logic       reset_alignment_n;
  logic       selftest_strap;
  logic       service_proc_boot_strap;
  logic       firmware_agent_strap;
  logic [1:0] socket_number_strap;
  logic       safe_boot_strap;
  logic       trust_agent_strap;
  logic       trust_platform_strap;
  logic       regulator_fault_flag;
  logic       overtemp_trip_n;
  logic       wake_dev_oe;
  logic       wake_plat_oe;
  logic       shared_quick_wake_n;
  assign shared_quick_wake_n = ~(wake_dev_oe | wake_plat_oe);
  modport device (
    input  power_stable_in, reset_alignment_n, selftest_strap, service_proc_boot_strap,
    input  firmware_agent_strap, socket_number_strap, safe_boot_strap,
    input  trust_agent_strap, trust_platform_strap, shared_quick_wake_n,
    output regulator_fault_flag, overtemp_trip_n, wake_dev_oe
  );
  modport platform (
    output power_stable_in, reset_alignment_n, selftest_strap, service_proc_boot_strap,
    output firmware_agent_strap, socket_number_strap, safe_boot_strap,
    output trust_agent_strap, trust_platform_strap, wake_plat_oe,
    input  regulator_fault_flag, overtemp_trip_n, shared_quick_wake_n
  );
endinterface : bsfw_link_if
`default_nettype wire

// *** src/bsfw_device.sv ***
// Socket end: strap capture, boot sequencing, GO handshake and fast wake.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "bsfw_defs.svh"
//
// Summary of operation
// - Self-test enable follows the captured strap.
// - Service boot strap low: boot locally or remotely.
// - Service boot strap high: minimal config, then stall.
// - Service processor writes GO; boot then continues.
// - Firmware and socket straps give legacy, agent, mode.
// - Boot waits for reset alignment input high.
// - Platform samples fault only 1.5 ms after power-good.
// - Platform trusts fault only with thermal trip.
// - Sleep break with pending work pulls fast wake.
// - Shared wired-OR wake line forces every socket awake.
// - Safe boot strap disables all clock gating.
// - Safe boot strap sampled after power-good rises.
// - Socket number yields sideband address and node id.
// - One node id per socket; 128 trackers.
// - Trust agent strap: 0 not agent, 1 agent.
// - Platform sets trust agent on legacy socket; bsfw_platform drives it from strap_set[2] for any socket.
// - Trust platform strap 0 means not trust enabled.
// - Trust platform 1 enables; firmware still enables.
// - Platform raises power-good cleanly once stable.
module bsfw_device (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Board link
  bsfw_link_if.device      link,
  // Internal events
  input  wire logic        wake_event,
  input  wire logic        regulator_error,
  input  wire logic        overtemp_event,
  // Control and status register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Boot outcome and sleep flag
  output logic             selftest_en,
  output logic             clock_gating_off,
  output logic             boot_done,
  output logic             is_legacy_socket,
  output logic             fw_agent_present,
  output logic             serial_link_mode,
  output logic             is_trust_agent,
  output logic             trust_platform_en,
  output logic      [7:0]  sideband_addr,
  output logic      [2:0]  node_id,
  output logic      [7:0]  ha_tracker_count,
  output logic             pkg_asleep
);
  // ---------------------------------------------------------------------------
  // Strap decode
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] decode_topology(input logic fa, input logic [1:0] sn);
    logic legacy;
    legacy = (sn == `BSFW_LEGACY_SOCKET);
    decode_topology = {legacy, fa & legacy, fa & ~legacy};
  endfunction : decode_topology

  bsfw_pkg::bsfw_state_e st_reg, st_next;
  bsfw_pkg::bsfw_pm_e    pm_reg, pm_next;
  logic        pg_q_reg, pg_q_next;
  logic        go_reg, go_next;
  logic        wakereq_reg, wakereq_next;
  logic        sleep_req_reg, sleep_req_next;
  logic        wake_oe_reg, wake_oe_next;
  logic        fault_reg, fault_next;
  logic        trip_n_reg, trip_n_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        sp_mode_reg, sp_mode_next;
  logic [15:0] outs_reg, outs_next;
  logic [7:0]  sba_reg, sba_next;
  logic [2:0]  nid_reg, nid_next;
  logic [2:0]  topo;

  assign topo = decode_topology(link.firmware_agent_strap, link.socket_number_strap);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    pm_next        = pm_reg;
    pg_q_next      = link.power_stable_in;
    go_next        = go_reg;
    wakereq_next   = wakereq_reg;
    sleep_req_next = sleep_req_reg;
    wake_oe_next   = 1'b0;
    fault_next     = fault_reg | regulator_error;
    trip_n_next    = trip_n_reg & ~overtemp_event & ~fault_next;
    rdata_next     = 32'h0000_0000;
    sp_mode_next   = sp_mode_reg;
    outs_next      = outs_reg;
    sba_next       = sba_reg;
    nid_next       = nid_reg;
    if (reg_wr && reg_addr == `BSFW_ADDR_CTRL) begin
      go_next        = reg_wdata[`BSFW_CTRL_GO];
      sleep_req_next = reg_wdata[`BSFW_CTRL_SLEEP];
      wakereq_next   = reg_wdata[`BSFW_CTRL_WAKEREQ];
    end
    if (reg_rd) begin
      case (reg_addr)
        `BSFW_ADDR_CTRL: rdata_next = {29'h0, wakereq_reg, sleep_req_reg, go_reg};
        `BSFW_ADDR_STAT: rdata_next = {24'h0, 1'b0, pm_reg == bsfw_pkg::BSFW_PM_SLEEP,
                                       sp_mode_reg, 2'h0, st_reg};
        `BSFW_ADDR_CFG:  rdata_next = {16'h0, sba_reg, 5'h0, nid_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
    case (st_reg)
      bsfw_pkg::BSFW_OFF: begin
        if (link.power_stable_in && !pg_q_reg) begin
          outs_next    = {link.selftest_strap, link.safe_boot_strap, topo,
                          link.trust_agent_strap, link.trust_platform_strap,
                          `BSFW_HA_TRACKERS, 1'b0};
          sp_mode_next = link.service_proc_boot_strap;
          sba_next     = `BSFW_SIDEBAND_MGMT_BUS_BASE + {6'h0, link.socket_number_strap};
          nid_next     = `BSFW_NODE_BASE + {1'b0, link.socket_number_strap};
          st_next      = bsfw_pkg::BSFW_ALIGN;
        end
      end
      bsfw_pkg::BSFW_ALIGN: begin
        if (link.reset_alignment_n) begin
          st_next = bsfw_pkg::BSFW_MINCFG;
        end
      end
      bsfw_pkg::BSFW_MINCFG: begin
        st_next = sp_mode_reg ? bsfw_pkg::BSFW_WAIT_GO : bsfw_pkg::BSFW_BOOT;
      end
      bsfw_pkg::BSFW_WAIT_GO: begin
        if (go_reg) begin
          st_next = bsfw_pkg::BSFW_BOOT;
        end
      end
      bsfw_pkg::BSFW_BOOT: begin
        st_next = bsfw_pkg::BSFW_RUN;
      end
      bsfw_pkg::BSFW_RUN: begin
        st_next = bsfw_pkg::BSFW_RUN;
      end
      default: st_next = bsfw_pkg::BSFW_OFF;
    endcase
    case (pm_reg)
      bsfw_pkg::BSFW_PM_ACTIVE: begin
        if (sleep_req_reg && st_reg == bsfw_pkg::BSFW_RUN && link.shared_quick_wake_n) begin
          pm_next = bsfw_pkg::BSFW_PM_SLEEP;
        end
      end
      bsfw_pkg::BSFW_PM_SLEEP: begin
        wake_oe_next = wake_event | wakereq_reg;
        if (!link.shared_quick_wake_n || wake_event || wakereq_reg) begin
          pm_next        = bsfw_pkg::BSFW_PM_ACTIVE;
          sleep_req_next = 1'b0;
        end
      end
      default: pm_next = bsfw_pkg::BSFW_PM_ACTIVE;
    endcase
    if (!link.power_stable_in) begin
      st_next      = bsfw_pkg::BSFW_OFF;
      pm_next      = bsfw_pkg::BSFW_PM_ACTIVE;
      outs_next[0] = 1'b0;
      // A GO left from an earlier power cycle must not skip the next stall.
      go_next      = 1'b0;
      fault_next   = 1'b0;
      trip_n_next  = 1'b1;
    end else begin
      outs_next[0] = (st_next == bsfw_pkg::BSFW_RUN);
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg        <= bsfw_pkg::BSFW_OFF;
      pm_reg        <= bsfw_pkg::BSFW_PM_ACTIVE;
      pg_q_reg      <= 1'b0;
      go_reg        <= 1'b0;
      wakereq_reg   <= 1'b0;
      sleep_req_reg <= 1'b0;
      wake_oe_reg   <= 1'b0;
      fault_reg     <= 1'b0;
      trip_n_reg    <= 1'b1;
      rdata_reg     <= 32'h0000_0000;
      sp_mode_reg   <= 1'b0;
      outs_reg      <= 16'h0000;
      sba_reg       <= 8'h00;
      nid_reg       <= 3'h0;
    end else if (clk_en) begin
      st_reg        <= st_next;
      pm_reg        <= pm_next;
      pg_q_reg      <= pg_q_next;
      go_reg        <= go_next;
      wakereq_reg   <= wakereq_next;
      sleep_req_reg <= sleep_req_next;
      wake_oe_reg   <= wake_oe_next;
      fault_reg     <= fault_next;
      trip_n_reg    <= trip_n_next;
      rdata_reg     <= rdata_next;
      sp_mode_reg   <= sp_mode_next;
      outs_reg      <= outs_next;
      sba_reg       <= sba_next;
      nid_reg       <= nid_next;
    end
  end

  // A latched fault also drives the trip so the platform has its qualifier.
  assign link.regulator_fault_flag = fault_reg;
  assign link.overtemp_trip_n      = trip_n_reg;
  assign link.wake_dev_oe          = wake_oe_reg;
  assign reg_rdata         = rdata_reg;
  assign selftest_en       = outs_reg[15];
  assign clock_gating_off  = outs_reg[14];
  assign is_legacy_socket  = outs_reg[13];
  assign fw_agent_present  = outs_reg[12];
  assign serial_link_mode  = outs_reg[11];
  assign is_trust_agent    = outs_reg[10];
  assign trust_platform_en = outs_reg[9];
  assign ha_tracker_count  = outs_reg[8:1];
  assign boot_done         = outs_reg[0];
  assign sideband_addr     = sba_reg;
  assign node_id           = nid_reg;
  // Sleep is the only power state with bit 0 set, so the flop bit is the flag.
  assign pkg_asleep        = pm_reg[0];
endmodule : bsfw_device
`default_nettype wire

// *** src/bsfw_platform.sv ***
// Platform end: drives straps and power-good, qualifies the regulator fault.
`timescale 1ns/1ps
`default_nettype none
`include "bsfw_defs.svh"
module bsfw_platform (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // Board link
  bsfw_link_if.platform   link,
  // Board controls
  input  wire logic       supplies_stable,
  input  wire logic       align_release,
  input  wire logic [8:0] strap_set,
  input  wire logic       wake_request,
  // Status
  output logic            fault_valid,
  output logic            wake_seen
);
  logic [`BSFW_CNT_W-1:0] cnt_reg, cnt_next;
  logic       pg_reg, pg_next;
  logic       al_reg, al_next;
  logic [8:0] straps_reg, straps_next;
  logic       woe_reg, woe_next;
  logic       fv_reg, fv_next;
  logic       ws_reg, ws_next;

  always_comb begin
    pg_next     = supplies_stable;
    al_next     = align_release & pg_reg;
    straps_next = pg_reg ? straps_reg : strap_set;
    woe_next    = wake_request;
    ws_next     = ~link.shared_quick_wake_n;
    cnt_next    = cnt_reg;
    if (!pg_reg) begin
      cnt_next = '0;
    end else if (cnt_reg != `BSFW_FAULT_WAIT_CYC) begin
      cnt_next = cnt_reg + 1'b1;
    end
    fv_next = (cnt_reg == `BSFW_FAULT_WAIT_CYC) && link.regulator_fault_flag
              && !link.overtemp_trip_n;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg    <= '0;
      pg_reg     <= 1'b0;
      al_reg     <= 1'b0;
      straps_reg <= 9'h000;
      woe_reg    <= 1'b0;
      fv_reg     <= 1'b0;
      ws_reg     <= 1'b0;
    end else if (clk_en) begin
      cnt_reg    <= cnt_next;
      pg_reg     <= pg_next;
      al_reg     <= al_next;
      straps_reg <= straps_next;
      woe_reg    <= woe_next;
      fv_reg     <= fv_next;
      ws_reg     <= ws_next;
    end
  end

  // Strap order: selftest, service boot, fw agent, socket[1:0], safe, trust agent, trust plat.
  assign link.power_stable_in         = pg_reg;
  assign link.reset_alignment_n       = al_reg;
  assign link.selftest_strap          = straps_reg[8];
  assign link.service_proc_boot_strap = straps_reg[7];
  assign link.firmware_agent_strap    = straps_reg[6];
  assign link.socket_number_strap     = straps_reg[5:4];
  assign link.safe_boot_strap         = straps_reg[3];
  assign link.trust_agent_strap       = straps_reg[2];
  assign link.trust_platform_strap    = straps_reg[1] | straps_reg[0];
  assign link.wake_plat_oe            = woe_reg;
  assign fault_valid                  = fv_reg;
  assign wake_seen                    = ws_reg;
endmodule : bsfw_platform
`default_nettype wire

// *** tb/bsfw_link_monitor.sv ***
// Concurrent checks on the board link between socket and platform.
`timescale 1ns/1ps
`default_nettype none
module bsfw_link_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Link signals
  input wire logic       power_stable_in,
  input wire logic       safe_boot_strap,
  input wire logic [1:0] socket_number_strap,
  input wire logic       regulator_fault_flag,
  input wire logic       overtemp_trip_n,
  input wire logic       wake_dev_oe,
  input wire logic       wake_plat_oe,
  input wire logic       shared_quick_wake_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  a_wake_wired_or: assert property (shared_quick_wake_n == !(wake_dev_oe | wake_plat_oe))
    else $error("wake line does not follow both drivers");
  a_fault_with_trip: assert property (regulator_fault_flag |-> !overtemp_trip_n)
    else $error("regulator fault without thermal trip");
  a_fault_after_pg: assert property (regulator_fault_flag |-> $past(power_stable_in))
    else $error("regulator fault while power-good low");
  a_fault_clears: assert property ($fell(power_stable_in) |-> ##[1:2] !regulator_fault_flag)
    else $error("fault kept after power-good fell");
  a_wake_pulse: assert property ($rose(wake_dev_oe) |=> !wake_dev_oe)
    else $error("fast wake pulse longer than one cycle");
  a_wake_needs_pg: assert property (!power_stable_in && !$past(power_stable_in) |-> !wake_dev_oe)
    else $error("fast wake driven while powered down");
  a_pg_clean: assert property ($rose(power_stable_in) |=> power_stable_in [*3])
    else $error("power-good glitched after rising");
  a_sock_settled: assert property ($rose(power_stable_in) |-> $stable(socket_number_strap))
    else $error("socket strap moving at power-good");
  a_safe_settled: assert property ($rose(power_stable_in) |-> $stable(safe_boot_strap))
    else $error("safe boot strap moving at power-good");
  // Main scenarios reached.
  c_pg_rise: cover property ($rose(power_stable_in));
  c_dev_wake: cover property ($rose(wake_dev_oe));
  c_plat_wake: cover property ($rose(wake_plat_oe));
  c_fault: cover property ($rose(regulator_fault_flag));
endmodule : bsfw_link_monitor
`default_nettype wire

// *** tb/boot_strap_and_fast_wake_bench.sv ***
// Self-checking bench joining the socket end and the platform end.
`timescale 1ns/1ps
`default_nettype none
module boot_strap_and_fast_wake_bench;
  logic clk_sys = 1'b0, rst = 1'b1, wake_event = 1'b0, regulator_error = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, supplies_stable = 1'b0, align_release = 1'b0;
  logic wake_request = 1'b0, low_seen = 1'b0, low_clr = 1'b0, overtemp_event = 1'b0;
  logic wake_seen;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [8:0] strap_set = 9'h000;
  logic selftest_en, clock_gating_off, boot_done, is_legacy_socket, fw_agent_present;
  logic serial_link_mode, is_trust_agent, trust_platform_en, pkg_asleep, fault_valid;
  logic [7:0] sideband_addr, ha_tracker_count;
  logic [2:0] node_id;
  int errors = 0, n_tests = 0, i;
  bsfw_link_if link ();
  bsfw_device bsfw_device_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link(link),
    .wake_event(wake_event), .regulator_error(regulator_error), .overtemp_event(overtemp_event),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .selftest_en(selftest_en), .clock_gating_off(clock_gating_off),
    .boot_done(boot_done), .is_legacy_socket(is_legacy_socket),
    .fw_agent_present(fw_agent_present), .serial_link_mode(serial_link_mode),
    .is_trust_agent(is_trust_agent), .trust_platform_en(trust_platform_en),
    .sideband_addr(sideband_addr), .node_id(node_id), .ha_tracker_count(ha_tracker_count),
    .pkg_asleep(pkg_asleep));
  bsfw_platform bsfw_platform_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link(link),
    .supplies_stable(supplies_stable), .align_release(align_release), .strap_set(strap_set),
    .wake_request(wake_request), .fault_valid(fault_valid), .wake_seen(wake_seen));
  bsfw_link_monitor bsfw_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .power_stable_in(link.power_stable_in), .safe_boot_strap(link.safe_boot_strap),
    .socket_number_strap(link.socket_number_strap),
    .regulator_fault_flag(link.regulator_fault_flag), .overtemp_trip_n(link.overtemp_trip_n),
    .wake_dev_oe(link.wake_dev_oe), .wake_plat_oe(link.wake_plat_oe),
    .shared_quick_wake_n(link.shared_quick_wake_n));
  always #10 clk_sys = ~clk_sys;
  // The wake pulse lasts one cycle, so it is latched here for a later look.
  always @(posedge clk_sys) begin
    if (low_clr) low_seen <= 1'b0;
    else if (link.shared_quick_wake_n === 1'b0) low_seen <= 1'b1;
  end
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task pwr(input logic [8:0] s, input logic al);
    supplies_stable <= 1'b0;
    repeat (4) @(posedge clk_sys);
    strap_set <= s; align_release <= al;
    repeat (4) @(posedge clk_sys);
    supplies_stable <= 1'b1;
    for (i = 0; i < 20 && link.power_stable_in !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask : pwr
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task t_local;
    pwr(9'b1_0_1_01_1_0_01, 1'b1);
    for (i = 0; i < 20 && boot_done !== 1'b1; i++) @(posedge clk_sys);
    chk(boot_done, 1'b1);
    chk({selftest_en, clock_gating_off, is_legacy_socket, fw_agent_present}, 4'b1100);
    chk({serial_link_mode, is_trust_agent, trust_platform_en}, 3'b101);
    chk({sideband_addr, 5'h0, node_id, ha_tracker_count}, 24'h310180);
    strap_set <= 9'h000;
    repeat (6) @(posedge clk_sys);
    chk({selftest_en, clock_gating_off, node_id, trust_platform_en}, 6'b110011);
    overtemp_event <= 1'b1;
    @(posedge clk_sys);
    overtemp_event <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({link.regulator_fault_flag, link.overtemp_trip_n, fault_valid}, 3'b000);
    $display("test local boot done");
  endtask : t_local
  task t_service;
    pwr(9'b0_1_0_00_0_1_00, 1'b0);
    repeat (8) @(posedge clk_sys);
    rd(4'h4);
    chk(d[2:0], 3'h1);
    align_release <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(4'h4);
    chk(d, 32'h23);
    chk(boot_done, 1'b0);
    wr(4'h0, 32'h1);
    for (i = 0; i < 10 && boot_done !== 1'b1; i++) @(posedge clk_sys);
    chk(boot_done, 1'b1);
    chk({is_legacy_socket, fw_agent_present, is_trust_agent, trust_platform_en}, 4'b1010);
    rd(4'h8);
    chk(d, 32'h3000);
    rd(4'hc);
    chk(d, 32'h0);
    $display("test service boot done");
  endtask : t_service
  task t_wake;
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, 32'h2);
      for (i = 0; i < 10 && pkg_asleep !== 1'b1; i++) @(posedge clk_sys);
      chk(pkg_asleep, 1'b1);
      low_clr <= 1'b1;
      @(posedge clk_sys);
      low_clr <= 1'b0;
      if (k == 0) wake_event <= 1'b1;
      if (k == 1) wr(4'h0, 32'h4);
      if (k == 2) wake_request <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      for (i = 0; i < 10 && pkg_asleep !== 1'b0; i++) @(posedge clk_sys);
      wake_request <= 1'b0;
      @(posedge clk_sys);
      chk({pkg_asleep, low_seen, wake_seen}, 3'b011);
    end
    $display("test fast wake done");
  endtask : t_wake
  task t_fault;
    pwr(9'h000, 1'b1);
    regulator_error <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({link.regulator_fault_flag, link.overtemp_trip_n, fault_valid}, 3'b100);
    repeat (75100) @(posedge clk_sys);
    chk(fault_valid, 1'b1);
    $display("test regulator fault done");
  endtask : t_fault
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_local();
    t_service();
    t_wake();
    t_fault();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
endmodule : boot_strap_and_fast_wake_bench
`default_nettype wire
